// >>> hw/pacc_consts.vh
// Constants for the pulse accumulator control block.
// What this block does
// - Accumulator enable works independently of timer enable.
// - Accumulator input is the channel 7 pin.
// - Mode bit: 0 event count, 1 gated.
// - Edge bit: 0 falling, 1 rising edges.
// - Gated: bit 0 high passes, 1 low passes.
// - No divide-by-64 clock while timer disabled.
// - Clock select: prescaler, accum, /256, /65536.
// - Accumulator disabled forces prescaler clock to counter.
// - Clock select change takes effect immediately.
// - Overflow enable gates overflow flag interrupt.
// - Input enable gates input flag interrupt.
// - Overflow flag sets on count wrap to zero.
// - Input flag on counted edge or gate trailing edge.
// - Write one clears flag only while enabled.
// - Fast clear: count access clears both flags.
// - Count register counts accumulator clocks and is writable by software.
// - Pin synchronised to bus clock before counting.
`ifndef PACC_CONSTS_VH
`define PACC_CONSTS_VH
`define PACC_OFS_CTRL 8'h20
`define PACC_OFS_FLAGS 8'h24
`define PACC_OFS_COUNT 8'h28
`define PACC_OFS_TSC 8'h2C
`define PACC_OFS_MASK 8'h30
`define PACC_CTRL_RST 8'h00
`define PACC_CTRL_WMASK 8'h7F
`define PACC_BIT_EN 6
`define PACC_BIT_MODE 5
`define PACC_BIT_EDGE 4
`define PACC_BIT_CLK1 3
`define PACC_BIT_CLK0 2
`define PACC_BIT_OVI 1
`define PACC_BIT_II 0
`define PACC_FLG_OV 1
`define PACC_FLG_IN 0
`define PACC_TSC_TEN 0
`define PACC_TSC_FFCA 1
`define PACC_DIV64 6'h3F
`define PACC_RESP_OKAY 2'h0
`define PACC_RESP_SLVERR 2'h2
`endif

// >>> hw/pacc_sync.v
// Two-flop synchroniser for the channel 7 pin.
`timescale 1ns/1ps
module pacc_sync (
	input wire clk, // Bus clock.
	input wire rstn, // Asynchronous reset, active low.
	input wire din, // Asynchronous level.
	output wire dout // Synchronised level.
);
	reg s1_r;
	reg s2_r;
	// The first stage feeds only the second stage.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
		end else begin
			s1_r <= din;
			s2_r <= s1_r;
		end
	end
	assign dout = s2_r;
endmodule // pacc_sync

// >>> hw/pacc_div64.v
// Divide-by-64 tick source counting bus clocks while the timer is enabled.
`timescale 1ns/1ps
`include "pacc_consts.vh"
module pacc_div64 (
	input wire clk, // Bus clock.
	input wire rstn, // Asynchronous reset, active low.
	input wire run, // Timer enable.
	output wire tick // One-cycle pulse every 64 cycles.
);
	reg [5:0] cnt_r;
	// The divider halts and clears while the timer is off.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_r <= 6'h00;
		end else if (!run) begin
			cnt_r <= 6'h00;
		end else begin
			cnt_r <= cnt_r + 6'h01;
		end
	end
	assign tick = run && (cnt_r == `PACC_DIV64);
endmodule // pacc_div64

// >>> hw/pacc_top.v
// Pulse accumulator control, flags, count and counter clock select.
`timescale 1ns/1ps
`include "pacc_consts.vh"
module pacc_top (
	input wire clk, // Bus clock, 125 MHz.
	input wire rstn, // Asynchronous reset, active low.
	input wire [7:0] s_axi_awaddr, // Write address.
	input wire s_axi_awvalid, // Write address valid.
	output wire s_axi_awready, // Write address ready.
	input wire [31:0] s_axi_wdata, // Write data.
	input wire [3:0] s_axi_wstrb, // Write strobes.
	input wire s_axi_wvalid, // Write data valid.
	output wire s_axi_wready, // Write data ready.
	output reg [1:0] s_axi_bresp, // Write response.
	output reg s_axi_bvalid, // Write response valid.
	input wire s_axi_bready, // Write response ready.
	input wire [7:0] s_axi_araddr, // Read address.
	input wire s_axi_arvalid, // Read address valid.
	output wire s_axi_arready, // Read address ready.
	output reg [31:0] s_axi_rdata, // Read data.
	output reg [1:0] s_axi_rresp, // Read response.
	output reg s_axi_rvalid, // Read data valid.
	input wire s_axi_rready, // Read data ready.
	input wire channel7_pin, // Shared channel 7 input pin.
	input wire presc_tick, // Timer prescaler clock tick.
	output wire cnt_tick, // Timer counter clock tick.
	output wire irq // Level interrupt.
);
	// ****************************************
	// Registers
	// ****************************************
	reg [7:0] ctrl_r;
	reg [1:0] flag_r;
	reg [1:0] mask_r;
	reg [1:0] tsc_r;
	reg [15:0] count_r;
	reg [15:0] pdiv_r;
	reg pin_d_r;
	reg [7:0] aw_addr_r;
	reg aw_have_r;
	reg [31:0] w_data_r;
	reg [3:0] w_strb_r;
	reg w_have_r;
	wire pin_s;
	wire tick64;
	wire accum_enable;
	wire accum_mode_select;
	wire accum_edge_select;
	wire timer_enable;
	wire fast_flag_clear_all;
	wire rise;
	wire fall;
	wire count_edge;
	wire gate_open;
	wire accum_clock_signal;
	wire wr_go;
	wire rd_go;
	wire [7:0] wa;
	wire clr_ok;
	wire cnt_access;
	wire wrap;
	wire set_in;
	wire [1:0] clr_w1;
	reg [1:0] flag_nxt;
	reg [31:0] rd_val;
	reg rd_err;

	// ****************************************
	// Pin path
	// ****************************************
	// The accumulator watches the channel 7 pin through a synchroniser.
	pacc_sync u_sync (
		.clk(clk),
		.rstn(rstn),
		.din(channel7_pin),
		.dout(pin_s)
	);

	// The gate clock exists only while the timer runs.
	pacc_div64 u_div (
		.clk(clk),
		.rstn(rstn),
		.run(timer_enable),
		.tick(tick64)
	);

	assign accum_enable = ctrl_r[`PACC_BIT_EN];
	assign accum_mode_select = ctrl_r[`PACC_BIT_MODE];
	assign accum_edge_select = ctrl_r[`PACC_BIT_EDGE];
	assign timer_enable = tsc_r[`PACC_TSC_TEN];
	assign fast_flag_clear_all = tsc_r[`PACC_TSC_FFCA];

	// Edge detection on the synchronised level.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pin_d_r <= 1'b0;
		end else begin
			pin_d_r <= pin_s;
		end
	end
	assign rise = pin_s && !pin_d_r;
	assign fall = !pin_s && pin_d_r;

	// Counted edge in event mode, gate level in gated mode.
	assign count_edge = accum_edge_select ? rise : fall;
	assign gate_open = accum_edge_select ? !pin_s : pin_s;
	assign accum_clock_signal = accum_enable &&
		(accum_mode_select ? (gate_open && tick64) : count_edge);
	// Trailing gate edge is the closing edge of the active level.
	assign set_in = accum_enable && (accum_mode_select ?
		(accum_edge_select ? rise : fall) : count_edge);

	// ****************************************
	// Counter clock select
	// ****************************************
	// Accumulator and the two dividers.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pdiv_r <= 16'h0000;
		end else if (accum_clock_signal) begin
			pdiv_r <= pdiv_r + 16'h0001;
		end
	end
	// The selection is combinational so a new field value acts at once.
	assign cnt_tick = (!accum_enable) ? presc_tick :
		(ctrl_r[3:2] == 2'b00) ? presc_tick :
		(ctrl_r[3:2] == 2'b01) ? accum_clock_signal :
		(ctrl_r[3:2] == 2'b10) ? (accum_clock_signal && pdiv_r[7:0] == 8'hFF) :
		(accum_clock_signal && pdiv_r == 16'hFFFF);

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	// Address and data are taken in either order and held until answered.
	assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
	assign s_axi_wready = !w_have_r && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
	assign rd_go = s_axi_arvalid && s_axi_arready;
	assign wa = aw_addr_r;

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			aw_addr_r <= 8'h00;
			aw_have_r <= 1'b0;
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
			w_have_r <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `PACC_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr_r <= s_axi_awaddr;
				aw_have_r <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
				w_have_r <= 1'b1;
			end
			if (wr_go) begin
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wa == `PACC_OFS_CTRL || wa == `PACC_OFS_FLAGS ||
					wa == `PACC_OFS_COUNT || wa == `PACC_OFS_TSC ||
					wa == `PACC_OFS_MASK) ? `PACC_RESP_OKAY : `PACC_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read decode.
	always @* begin
		rd_val = 32'h00000000;
		rd_err = 1'b0;
		case (s_axi_araddr)
			`PACC_OFS_CTRL: rd_val = {24'h000000, 1'b0, ctrl_r[6:0]};
			`PACC_OFS_FLAGS: rd_val = {30'h00000000, flag_r};
			`PACC_OFS_COUNT: rd_val = {16'h0000, count_r};
			`PACC_OFS_TSC: rd_val = {30'h00000000, tsc_r};
			`PACC_OFS_MASK: rd_val = {30'h00000000, mask_r};
			default: rd_err = 1'b1;
		endcase
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `PACC_RESP_OKAY;
		end else if (rd_go) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_val;
			s_axi_rresp <= rd_err ? `PACC_RESP_SLVERR : `PACC_RESP_OKAY;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ****************************************
	// Control, mask and count
	// ****************************************
	// Byte lane 0 carries every control field.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_r <= `PACC_CTRL_RST;
			tsc_r <= 2'h0;
			mask_r <= 2'h0;
		end else if (wr_go && w_strb_r[0]) begin
			if (wa == `PACC_OFS_CTRL) begin
				ctrl_r <= w_data_r[7:0] & `PACC_CTRL_WMASK;
			end
			if (wa == `PACC_OFS_TSC) begin
				tsc_r <= w_data_r[1:0];
			end
			if (wa == `PACC_OFS_MASK) begin
				mask_r <= w_data_r[1:0];
			end
		end
	end

	assign wrap = accum_clock_signal && (count_r == 16'hFFFF);
	// A software write wins over a simultaneous count edge.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			count_r <= 16'h0000;
		end else if (wr_go && wa == `PACC_OFS_COUNT && w_strb_r[1:0] == 2'h3) begin
			count_r <= w_data_r[15:0];
		end else if (wr_go && wa == `PACC_OFS_COUNT && w_strb_r[0]) begin
			count_r <= {count_r[15:8], w_data_r[7:0]};
		end else if (wr_go && wa == `PACC_OFS_COUNT && w_strb_r[1]) begin
			count_r <= {w_data_r[15:8], count_r[7:0]};
		end else if (accum_clock_signal) begin
			count_r <= count_r + 16'h0001;
		end
	end

	// ****************************************
	// Flags and interrupt
	// ****************************************
	assign clr_ok = timer_enable || accum_enable;
	assign clr_w1 = (wr_go && wa == `PACC_OFS_FLAGS && w_strb_r[0] && clr_ok) ?
		w_data_r[1:0] : 2'h0;
	assign cnt_access = fast_flag_clear_all && ((wr_go && wa == `PACC_OFS_COUNT) ||
		(rd_go && s_axi_araddr == `PACC_OFS_COUNT));

	// Clears apply first, then events set, so a set in the same cycle wins.
	always @* begin
		flag_nxt = flag_r & ~clr_w1;
		if (cnt_access) begin
			flag_nxt = 2'h0;
		end
		if (wrap) begin
			flag_nxt[`PACC_FLG_OV] = 1'b1;
		end
		if (set_in) begin
			flag_nxt[`PACC_FLG_IN] = 1'b1;
		end
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			flag_r <= 2'h0;
		end else begin
			flag_r <= flag_nxt;
		end
	end

	// Enables in the control register and the mask register both gate each flag.
	assign irq = (flag_r[`PACC_FLG_OV] && ctrl_r[`PACC_BIT_OVI] && mask_r[`PACC_FLG_OV]) ||
		(flag_r[`PACC_FLG_IN] && ctrl_r[`PACC_BIT_II] && mask_r[`PACC_FLG_IN]);
endmodule // pacc_top

// >>> tb/pacc_pin_model.sv
// Model of the external event source on the channel 7 pin.
`timescale 1ns/1ps
module pacc_pin_model (
	input wire clk, // Bus clock.
	output reg pin // Channel 7 pin level.
);
	// Pin starts low and changes only after a clock edge.
	initial pin = 1'b0;
	// Edges are eight cycles apart, well beyond the synchroniser delay.
	task toggle(input integer n);
		repeat (n) begin
			repeat (8) @(posedge clk);
			pin <= ~pin;
		end
		repeat (8) @(posedge clk);
	endtask
	// Sets a gate level.
	task level(input v);
		@(posedge clk);
		pin <= v;
	endtask
endmodule // pacc_pin_model

// >>> tb/pacc_top_assertions.sv
// Port checker for the pulse accumulator control block.
`timescale 1ns/1ps
module pacc_top_assertions (
	input wire clk, // Bus clock.
	input wire rstn, // Reset, active low.
	input wire [7:0] s_axi_awaddr, // Write address.
	input wire s_axi_awvalid, // Write address valid.
	input wire s_axi_awready, // Write address ready.
	input wire [31:0] s_axi_wdata, // Write data.
	input wire s_axi_wvalid, // Write data valid.
	input wire s_axi_wready, // Write data ready.
	input wire s_axi_bvalid, // Write response valid.
	input wire s_axi_bready, // Write response ready.
	input wire s_axi_arvalid, // Read address valid.
	input wire s_axi_arready, // Read address ready.
	input wire s_axi_rvalid, // Read data valid.
	input wire channel7_pin, // Pin.
	input wire presc_tick, // Prescaler tick.
	input wire cnt_tick, // Counter tick.
	input wire irq // Interrupt.
);
	// ****************************
	// Shadow of control registers
	// ****************************
	reg [7:0] aw_r, wd_r, ctl_r, tsc_r;
	reg pend_r;
	// Register checks are held off while a write is in flight.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			aw_r <= 8'h00;
			wd_r <= 8'h00;
			ctl_r <= 8'h00;
			tsc_r <= 8'h00;
			pend_r <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_r <= s_axi_awaddr;
				pend_r <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) wd_r <= s_axi_wdata[7:0];
			if (s_axi_bvalid && s_axi_bready) begin
				pend_r <= 1'b0;
				if (aw_r == 8'h20) ctl_r <= wd_r & 8'h7F;
				if (aw_r == 8'h2C) tsc_r <= wd_r;
			end
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	a_prescaler_path: assert property (!pend_r && !ctl_r[6] |-> cnt_tick == presc_tick)
		else $error("counter tick not from prescaler while disabled");
	a_clock_select: assert property (!pend_r && ctl_r[6] && ctl_r[3:2] == 2'h0
		|-> cnt_tick == presc_tick)
		else $error("select 00 does not pass prescaler tick");
	a_no_div_clock: assert property (!pend_r && ctl_r[6:5] == 2'h3 && ctl_r[3:2] == 2'h1
		&& !tsc_r[0] |-> !cnt_tick)
		else $error("gated tick while timer disabled");
	a_gate_closed: assert property (!channel7_pin [*5] ##0 (!pend_r && ctl_r[6:4] == 3'h6
		&& ctl_r[3:2] == 2'h1) |-> !cnt_tick)
		else $error("gated tick with gate closed");
	a_irq_inhibit: assert property (!pend_r && ctl_r[1:0] == 2'h0 |-> !irq)
		else $error("interrupt while both enables off");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write address taken during response");
	a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken during response");
endmodule // pacc_top_assertions
bind pacc_top pacc_top_assertions pacc_top_assertions_i (.clk, .rstn, .s_axi_awaddr,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.channel7_pin, .presc_tick, .cnt_tick, .irq);

// >>> tb/pacc_top_bench.sv
// Self-checking bench for the pulse accumulator control block.
`timescale 1ns/1ps
module pacc_top_bench;
	reg clk = 1'b0, rstn = 1'b0;
	reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	reg [31:0] s_axi_wdata = 32'h0, rv;
	reg [3:0] s_axi_wstrb = 4'hF;
	reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	reg s_axi_bready = 1'b1, s_axi_rready = 1'b1, presc_tick = 1'b0;
	reg [1:0] pdiv = 2'h0, rr;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire cnt_tick, irq, channel7_pin;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	integer errors = 0, total_checks = 0, ticks = 0, t0;
	always #4 clk = ~clk;
	// Prescaler tick every fourth cycle; counter ticks are tallied.
	always @(posedge clk) begin
		pdiv <= pdiv + 2'h1;
		presc_tick <= (pdiv == 2'h3);
		if (cnt_tick === 1'b1) ticks <= ticks + 1;
	end
	pacc_top pacc_top_i (.clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .channel7_pin,
		.presc_tick, .cnt_tick, .irq);
	pacc_pin_model pacc_pin_model_i (.clk, .pin(channel7_pin));
	// ****************************
	// Shared tasks
	// ****************************
	task report_and_stop;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task chk(input [31:0] g, input [31:0] e);
		total_checks = total_checks + 1;
		if (g !== e) begin
			errors = errors + 1;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	// Write with both channels offered together; each drops once taken.
	task wr(input [7:0] a, input [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		@(posedge clk);
		while (s_axi_bvalid !== 1'b1) begin
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			@(posedge clk);
		end
		rr = s_axi_bresp;
	endtask
	task rd(input [7:0] a, output [31:0] d, output [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		@(posedge clk);
		while (s_axi_rvalid !== 1'b1) begin
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			@(posedge clk);
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask
	task rc(input [7:0] a, input [31:0] e);
		rd(a, rv, rr);
		chk(rv, e);
	endtask
	// Hang guard.
	initial begin
		repeat (20000) @(posedge clk);
		errors = errors + 1;
		report_and_stop;
	end
	// ****************************
	// Scenarios
	// ****************************
	// Reset values, the reserved bit and an unmapped address on both paths.
	task sc_regs;
		rc(8'h20, 32'h0);
		rc(8'h24, 32'h0);
		wr(8'h20, 32'hFF);
		rc(8'h20, 32'h7F);
		wr(8'h04, 32'h1);
		chk({30'h0, rr}, 32'h2);
		rd(8'h04, rv, rr);
		chk({30'h0, rr}, 32'h2);
	endtask
	// Rising edges in event mode feed the count and the counter clock.
	task sc_event;
		wr(8'h20, 32'h54);
		wr(8'h30, 32'h3);
		t0 = ticks;
		pacc_pin_model_i.toggle(6);
		rc(8'h28, 32'h3);
		chk(ticks - t0, 32'h3);
		rc(8'h24, 32'h1);
		wr(8'h24, 32'h3);
		rc(8'h24, 32'h0);
	endtask
	// Falling edge wraps the count and raises the overflow interrupt.
	task sc_wrap;
		wr(8'h20, 32'h46);
		wr(8'h28, 32'hFFFF);
		pacc_pin_model_i.toggle(2);
		rc(8'h28, 32'h0);
		rc(8'h24, 32'h3);
		chk({31'h0, irq}, 32'h1);
		wr(8'h24, 32'h2);
		rc(8'h24, 32'h1);
		chk({31'h0, irq}, 32'h0);
	endtask
	// Clearing is refused while both units are off; fast clear still works.
	task sc_clear;
		wr(8'h20, 32'h0);
		wr(8'h24, 32'h1);
		rc(8'h24, 32'h1);
		wr(8'h2C, 32'h2);
		rd(8'h28, rv, rr);
		rc(8'h24, 32'h0);
	endtask
	// Gated accumulation with the timer running, then with it stopped.
	task sc_gated;
		wr(8'h2C, 32'h1);
		wr(8'h20, 32'h64);
		wr(8'h28, 32'h0);
		pacc_pin_model_i.level(1'b1);
		repeat (300) @(posedge clk);
		pacc_pin_model_i.level(1'b0);
		repeat (8) @(posedge clk);
		rd(8'h28, rv, rr);
		chk({31'h0, rv >= 32'h4 && rv <= 32'h5}, 32'h1);
		rc(8'h24, 32'h1);
		wr(8'h2C, 32'h0);
		wr(8'h28, 32'h0);
		pacc_pin_model_i.level(1'b1);
		repeat (200) @(posedge clk);
		rc(8'h28, 32'h0);
	endtask
	// Counter clock for select 00, for a disabled accumulator and for the /256 tap.
	task sc_select;
		wr(8'h20, 32'h40);
		t0 = ticks;
		repeat (40) @(posedge clk);
		chk(ticks - t0, 32'hA);
		wr(8'h20, 32'h0C);
		t0 = ticks;
		repeat (40) @(posedge clk);
		chk(ticks - t0, 32'hA);
		wr(8'h20, 32'h58);
		t0 = ticks;
		pacc_pin_model_i.toggle(512);
		chk(ticks - t0, 32'h1);
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		sc_regs;
		sc_event;
		sc_wrap;
		sc_clear;
		sc_gated;
		sc_select;
		report_and_stop;
	end
endmodule // pacc_top_bench
